// ### backplane_mailbox_pkg.sv
package backplane_mailbox_pkg;
  // ----------------------------------------------------------------
  // widths and areas
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int REG_ADDR_W = 13;
  localparam int CMD_WORDS = 64;
  localparam int RESP_WORDS = 4;
  localparam int RESP_BASE = 2;
  localparam int MAX_WINDOW = 4000;
  localparam int DB_WORDS = 4096;
  localparam logic [15:0] AREA_BASE = 16'h0001;
  localparam logic [15:0] SEQ_STEP = 16'h0001;

  // ----------------------------------------------------------------
  // block identifiers
  // ----------------------------------------------------------------
  localparam logic [15:0] BLK_STATUS = 16'h2422;
  localparam logic [15:0] BLK_USER_CMD = 16'h26AD;
  localparam logic [15:0] BLK_CMD_CTRL = 16'h26AE;
  localparam logic [15:0] BLK_EVENTS = 16'h26AF;
  localparam logic [15:0] BLK_CMD_ERR = 16'h26DE;
  localparam logic [15:0] BLK_TIME_RD = 16'h26F2;
  localparam logic [15:0] BLK_TIME_SET = 16'h26F3;
  localparam logic [15:0] BLK_WARM = 16'h270E;
  localparam logic [15:0] BLK_COLD = 16'h270F;

  // ----------------------------------------------------------------
  // register map (word offsets, bit 12 of address selects database)
  // ----------------------------------------------------------------
  localparam int DB_SEL_BIT = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_RD_START = 12'h001;
  localparam logic [11:0] OFF_RD_COUNT = 12'h002;
  localparam logic [11:0] OFF_WR_START = 12'h003;
  localparam logic [11:0] OFF_WR_COUNT = 12'h004;
  localparam logic [11:0] OFF_IN_START = 12'h005;
  localparam logic [11:0] OFF_HOLD_START = 12'h006;
  localparam logic [11:0] OFF_STATUS = 12'h007;
  localparam logic [11:0] OFF_SCAN_CNT = 12'h008;
  localparam logic [11:0] OFF_LAST_SEQ = 12'h009;
  localparam logic [11:0] OFF_EV_CNT = 12'h00A;
  localparam int CTRL_CFG_DONE = 0;
  localparam int CTRL_PASS_EV = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] RST_RD_START = 12'h000;
  localparam logic [11:0] RST_RD_COUNT = 12'h032;
  localparam logic [11:0] RST_WR_START = 12'h3E8;
  localparam logic [11:0] RST_WR_COUNT = 12'h032;
  localparam logic [15:0] RST_AREA_START = 16'h0001;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TIME_TICK_NS = 1000000;
  localparam int TIME_TICK_CYCLES = TIME_TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [11:0] {
    ST_INIT_BP = 12'h001,
    ST_CLEAR = 12'h002,
    ST_INIT_SER = 12'h004,
    ST_LOAD_CFG = 12'h008,
    ST_INIT_DB = 12'h010,
    ST_DBG = 12'h020,
    ST_IDLE = 12'h040,
    ST_PULL_ADDR = 12'h080,
    ST_PULL_WAIT = 12'h100,
    ST_PULL_DATA = 12'h200,
    ST_CMD = 12'h400,
    ST_PUSH = 12'h800
  } mbox_state_t;
endpackage

// ### backplane_cmd_mailbox.sv
// Operation
// - power-up steps run in fixed order
// - no serial traffic before configuration loaded
// - every scan moves both whole windows
// - four values set window starts and counts
// - event option gates forwarding via block 9903
// - processor area starts counted from one
// - scan held until both windows moved
// - windows up to 4000 words each way
// - words 0-63 command, data from start+64
// - command words never enter the database
// - listed block IDs are recognised
// - only sequence change triggers a request
// - word 1 block ID, then 62 words
// - valid block answered, sequence set plus one
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module backplane_cmd_mailbox
  import backplane_mailbox_pkg::*;
#(
  parameter int WINDOW_MAX = MAX_WINDOW,
  parameter int TICK_CYCLES = TIME_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic scan_end,
  output logic scan_hold,
  output logic [15:0] proc_addr,
  output logic proc_rd,
  output logic proc_wr,
  output logic [DATA_W-1:0] proc_wdata,
  input wire logic [DATA_W-1:0] proc_rdata,
  input wire logic event_in,
  output logic backplane_ready,
  output logic serial_init,
  output logic serial_enable,
  output logic debug_port_enable,
  output logic warm_restart,
  output logic cold_restart
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] area_word(input logic [15:0] start, input logic [12:0] idx);
    area_word = start - AREA_BASE + {3'h0, idx};
  endfunction

  function automatic logic id_known(input logic [15:0] id);
    case (id)
      BLK_STATUS, BLK_USER_CMD, BLK_CMD_CTRL, BLK_EVENTS, BLK_CMD_ERR,
      BLK_TIME_RD, BLK_TIME_SET, BLK_WARM, BLK_COLD: id_known = 1'b1;
      default: id_known = 1'b0;
    endcase
  endfunction

  function automatic logic [11:0] clamp_count(input logic [15:0] v);
    clamp_count = (v > 16'(WINDOW_MAX)) ? 12'(WINDOW_MAX) : v[11:0];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam logic [12:0] CMD_LAST = 13'(CMD_WORDS - 1);
  localparam logic [12:0] DB_LAST = 13'(DB_WORDS - 1);

  logic [DATA_W-1:0] db [DB_WORDS];
  mbox_state_t state_r, state_nxt;
  logic [12:0] idx_r, idx_nxt;
  logic scan_s1_r, scan_s2_r, scan_s3_r, scan_lvl_r, scan_lvl_nxt;
  logic cfg_done_r, cfg_done_nxt, pass_ev_r, pass_ev_nxt;
  logic [11:0] rd_start_r, rd_start_nxt, rd_count_r, rd_count_nxt;
  logic [11:0] wr_start_r, wr_start_nxt, wr_count_r, wr_count_nxt;
  logic [15:0] in_start_r, in_start_nxt, hold_start_r, hold_start_nxt;
  logic [15:0] scan_count_r, scan_count_nxt, ev_count_r, ev_count_nxt;
  logic [31:0] time_r, time_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic [15:0] last_seq_r, last_seq_nxt, req_seq_r, req_seq_nxt, req_id_r, req_id_nxt;
  logic [15:0] req_w1_r, req_w1_nxt, req_w2_r, req_w2_nxt;
  logic [15:0] resp_seq_r, resp_seq_nxt, resp_id_r, resp_id_nxt;
  logic [15:0] resp_w_r [RESP_WORDS];
  logic [15:0] resp_w_nxt [RESP_WORDS];
  logic [15:0] proc_addr_r, proc_addr_nxt;
  logic proc_rd_r, proc_rd_nxt, proc_wr_r, proc_wr_nxt;
  logic [DATA_W-1:0] proc_wdata_r, proc_wdata_nxt, reg_rdata_r, reg_rdata_nxt;
  logic scan_hold_r, scan_hold_nxt, bp_ready_r, bp_ready_nxt, ser_init_r, ser_init_nxt;
  logic ser_en_r, ser_en_nxt, dbg_en_r, dbg_en_nxt, warm_r, warm_nxt, cold_r, cold_nxt;
  logic db_we;
  logic [11:0] db_wa;
  logic [DATA_W-1:0] db_wd;
  logic [11:0] reg_off;
  logic [12:0] pull_last, push_last;
  logic [15:0] push_word;

  assign reg_off = reg_addr[11:0];
  assign pull_last = CMD_LAST + {1'b0, wr_count_r};
  assign push_last = CMD_LAST + {1'b0, rd_count_r};

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    scan_lvl_nxt = (scan_s2_r == scan_s3_r) ? scan_s3_r : scan_lvl_r;
    cfg_done_nxt = cfg_done_r;
    pass_ev_nxt = pass_ev_r;
    rd_start_nxt = rd_start_r;
    rd_count_nxt = rd_count_r;
    wr_start_nxt = wr_start_r;
    wr_count_nxt = wr_count_r;
    in_start_nxt = in_start_r;
    hold_start_nxt = hold_start_r;
    scan_count_nxt = scan_count_r;
    ev_count_nxt = ev_count_r;
    tick_nxt = tick_r + 32'h0000_0001;
    time_nxt = time_r;
    last_seq_nxt = last_seq_r;
    req_seq_nxt = req_seq_r;
    req_id_nxt = req_id_r;
    req_w1_nxt = req_w1_r;
    req_w2_nxt = req_w2_r;
    resp_seq_nxt = resp_seq_r;
    resp_id_nxt = resp_id_r;
    resp_w_nxt = resp_w_r;
    proc_addr_nxt = proc_addr_r;
    proc_rd_nxt = 1'b0;
    proc_wr_nxt = 1'b0;
    proc_wdata_nxt = proc_wdata_r;
    reg_rdata_nxt = '0;
    // transfer states sit above idle in the one-hot order
    scan_hold_nxt = (state_r > ST_IDLE);
    bp_ready_nxt = bp_ready_r;
    ser_init_nxt = ser_init_r;
    ser_en_nxt = ser_en_r;
    dbg_en_nxt = dbg_en_r;
    warm_nxt = 1'b0;
    cold_nxt = 1'b0;
    db_we = 1'b0;
    db_wa = '0;
    db_wd = '0;
    push_word = '0;

    if (tick_r >= 32'(TICK_CYCLES - 1)) begin
      tick_nxt = '0;
      time_nxt = time_r + 32'h0000_0001;
    end
    if (event_in && pass_ev_r && ev_count_r != 16'hFFFF) begin
      ev_count_nxt = ev_count_r + 16'h0001;
    end

    // register port
    if (reg_rd) begin
      if (reg_addr[DB_SEL_BIT]) begin
        reg_rdata_nxt = db[reg_off];
      end else begin
        case (reg_off)
          OFF_CTRL: reg_rdata_nxt = {14'h0, pass_ev_r, cfg_done_r};
          OFF_RD_START: reg_rdata_nxt = {4'h0, rd_start_r};
          OFF_RD_COUNT: reg_rdata_nxt = {4'h0, rd_count_r};
          OFF_WR_START: reg_rdata_nxt = {4'h0, wr_start_r};
          OFF_WR_COUNT: reg_rdata_nxt = {4'h0, wr_count_r};
          OFF_IN_START: reg_rdata_nxt = in_start_r;
          OFF_HOLD_START: reg_rdata_nxt = hold_start_r;
          OFF_STATUS: reg_rdata_nxt = {4'h0, state_r};
          OFF_SCAN_CNT: reg_rdata_nxt = scan_count_r;
          OFF_LAST_SEQ: reg_rdata_nxt = last_seq_r;
          OFF_EV_CNT: reg_rdata_nxt = ev_count_r;
          default: reg_rdata_nxt = '0;
        endcase
      end
    end
    if (reg_wr && !reg_addr[DB_SEL_BIT]) begin
      case (reg_off)
        OFF_CTRL: begin
          cfg_done_nxt = reg_wdata[CTRL_CFG_DONE];
          pass_ev_nxt = reg_wdata[CTRL_PASS_EV];
        end
        OFF_RD_START: rd_start_nxt = reg_wdata[11:0];
        OFF_RD_COUNT: rd_count_nxt = clamp_count(reg_wdata);
        OFF_WR_START: wr_start_nxt = reg_wdata[11:0];
        OFF_WR_COUNT: wr_count_nxt = clamp_count(reg_wdata);
        OFF_IN_START: in_start_nxt = reg_wdata;
        OFF_HOLD_START: hold_start_nxt = reg_wdata;
        default: ;
      endcase
    end

    case (state_r)
      ST_INIT_BP: begin
        bp_ready_nxt = 1'b1;
        idx_nxt = '0;
        state_nxt = ST_CLEAR;
      end
      ST_CLEAR: begin
        db_we = 1'b1;
        db_wa = idx_r[11:0];
        idx_nxt = idx_r + 13'h0001;
        if (idx_r == DB_LAST) begin
          state_nxt = ST_INIT_SER;
        end
      end
      ST_INIT_SER: begin
        ser_init_nxt = 1'b1;
        state_nxt = ST_LOAD_CFG;
      end
      ST_LOAD_CFG: begin
        if (cfg_done_r) begin
          state_nxt = ST_INIT_DB;
        end
      end
      ST_INIT_DB: begin
        last_seq_nxt = '0;
        resp_seq_nxt = '0;
        resp_id_nxt = '0;
        for (int i = 0; i < RESP_WORDS; i++) begin
          resp_w_nxt[i] = '0;
        end
        ev_count_nxt = '0;
        state_nxt = ST_DBG;
      end
      ST_DBG: begin
        dbg_en_nxt = 1'b1;
        ser_en_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (reg_wr && reg_addr[DB_SEL_BIT]) begin
          db_we = 1'b1;
          db_wa = reg_off;
          db_wd = reg_wdata;
        end
        if (scan_lvl_nxt && !scan_lvl_r) begin
          scan_hold_nxt = 1'b1;
          scan_count_nxt = scan_count_r + 16'h0001;
          idx_nxt = '0;
          state_nxt = ST_PULL_ADDR;
        end
      end
      ST_PULL_ADDR: begin
        proc_addr_nxt = area_word(hold_start_r, idx_r);
        proc_rd_nxt = 1'b1;
        state_nxt = ST_PULL_WAIT;
      end
      ST_PULL_WAIT: state_nxt = ST_PULL_DATA;
      ST_PULL_DATA: begin
        if (idx_r < 13'(CMD_WORDS)) begin
          case (idx_r[5:0])
            6'h00: req_seq_nxt = proc_rdata;
            6'h01: req_id_nxt = proc_rdata;
            6'h02: req_w1_nxt = proc_rdata;
            6'h03: req_w2_nxt = proc_rdata;
            default: ;
          endcase
        end else begin
          db_we = 1'b1;
          db_wa = wr_start_r + 12'(idx_r - 13'(CMD_WORDS));
          db_wd = proc_rdata;
        end
        idx_nxt = idx_r + 13'h0001;
        state_nxt = (idx_r == pull_last) ? ST_CMD : ST_PULL_ADDR;
      end
      ST_CMD: begin
        idx_nxt = '0;
        state_nxt = ST_PUSH;
        if (req_seq_r != last_seq_r) begin
          last_seq_nxt = req_seq_r;
          if (id_known(req_id_r)) begin
            resp_seq_nxt = req_seq_r + SEQ_STEP;
            resp_id_nxt = req_id_r;
            for (int i = 0; i < RESP_WORDS; i++) begin
              resp_w_nxt[i] = '0;
            end
            case (req_id_r)
              BLK_STATUS: begin
                resp_w_nxt[0] = scan_count_r;
                resp_w_nxt[1] = ev_count_r;
              end
              BLK_EVENTS: begin
                if (pass_ev_r) begin
                  resp_w_nxt[0] = ev_count_r;
                  ev_count_nxt = (event_in) ? 16'h0001 : 16'h0000;
                end
              end
              BLK_TIME_RD: begin
                resp_w_nxt[0] = time_r[31:16];
                resp_w_nxt[1] = time_r[15:0];
              end
              BLK_TIME_SET: begin
                time_nxt = {req_w1_r, req_w2_r};
                tick_nxt = '0;
                resp_w_nxt[0] = req_w1_r;
                resp_w_nxt[1] = req_w2_r;
              end
              BLK_WARM: warm_nxt = 1'b1;
              BLK_COLD: cold_nxt = 1'b1;
              default: ;
            endcase
          end
        end
      end
      ST_PUSH: begin
        if (idx_r < 13'(CMD_WORDS)) begin
          if (idx_r == 13'h0000) begin
            push_word = resp_seq_r;
          end else if (idx_r == 13'h0001) begin
            push_word = resp_id_r;
          end else if (idx_r < 13'(RESP_BASE + RESP_WORDS)) begin
            push_word = resp_w_r[2'(idx_r - 13'(RESP_BASE))];
          end
        end else begin
          push_word = db[rd_start_r + 12'(idx_r - 13'(CMD_WORDS))];
        end
        proc_addr_nxt = area_word(in_start_r, idx_r);
        proc_wdata_nxt = push_word;
        proc_wr_nxt = 1'b1;
        idx_nxt = idx_r + 13'h0001;
        if (idx_r == push_last) begin
          state_nxt = ST_IDLE;
          if (cold_r) begin
            state_nxt = ST_INIT_BP;
            cfg_done_nxt = 1'b0;
            bp_ready_nxt = 1'b0;
            ser_init_nxt = 1'b0;
            ser_en_nxt = 1'b0;
            dbg_en_nxt = 1'b0;
          end else if (warm_r) begin
            state_nxt = ST_INIT_DB;
            ser_en_nxt = 1'b0;
          end
        end
        warm_nxt = warm_r;
        cold_nxt = cold_r;
      end
      default: state_nxt = ST_INIT_BP;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (db_we) begin
      db[db_wa] <= db_wd;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_INIT_BP;
      idx_r <= '0;
      scan_s1_r <= 1'b0;
      scan_s2_r <= 1'b0;
      scan_s3_r <= 1'b0;
      scan_lvl_r <= 1'b0;
      cfg_done_r <= 1'b0;
      pass_ev_r <= 1'b0;
      rd_start_r <= RST_RD_START;
      rd_count_r <= RST_RD_COUNT;
      wr_start_r <= RST_WR_START;
      wr_count_r <= RST_WR_COUNT;
      in_start_r <= RST_AREA_START;
      hold_start_r <= RST_AREA_START;
      scan_count_r <= '0;
      ev_count_r <= '0;
      tick_r <= '0;
      time_r <= '0;
      last_seq_r <= '0;
      req_seq_r <= '0;
      req_id_r <= '0;
      req_w1_r <= '0;
      req_w2_r <= '0;
      resp_seq_r <= '0;
      resp_id_r <= '0;
      for (int i = 0; i < RESP_WORDS; i++) begin
        resp_w_r[i] <= '0;
      end
      proc_addr_r <= '0;
      proc_rd_r <= 1'b0;
      proc_wr_r <= 1'b0;
      proc_wdata_r <= '0;
      reg_rdata_r <= '0;
      scan_hold_r <= 1'b0;
      bp_ready_r <= 1'b0;
      ser_init_r <= 1'b0;
      ser_en_r <= 1'b0;
      dbg_en_r <= 1'b0;
      warm_r <= 1'b0;
      cold_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      scan_s1_r <= scan_end;
      scan_s2_r <= scan_s1_r;
      scan_s3_r <= scan_s2_r;
      scan_lvl_r <= scan_lvl_nxt;
      cfg_done_r <= cfg_done_nxt;
      pass_ev_r <= pass_ev_nxt;
      rd_start_r <= rd_start_nxt;
      rd_count_r <= rd_count_nxt;
      wr_start_r <= wr_start_nxt;
      wr_count_r <= wr_count_nxt;
      in_start_r <= in_start_nxt;
      hold_start_r <= hold_start_nxt;
      scan_count_r <= scan_count_nxt;
      ev_count_r <= ev_count_nxt;
      tick_r <= tick_nxt;
      time_r <= time_nxt;
      last_seq_r <= last_seq_nxt;
      req_seq_r <= req_seq_nxt;
      req_id_r <= req_id_nxt;
      req_w1_r <= req_w1_nxt;
      req_w2_r <= req_w2_nxt;
      resp_seq_r <= resp_seq_nxt;
      resp_id_r <= resp_id_nxt;
      resp_w_r <= resp_w_nxt;
      proc_addr_r <= proc_addr_nxt;
      proc_rd_r <= proc_rd_nxt;
      proc_wr_r <= proc_wr_nxt;
      proc_wdata_r <= proc_wdata_nxt;
      reg_rdata_r <= reg_rdata_nxt;
      scan_hold_r <= scan_hold_nxt;
      bp_ready_r <= bp_ready_nxt;
      ser_init_r <= ser_init_nxt;
      ser_en_r <= ser_en_nxt;
      dbg_en_r <= dbg_en_nxt;
      warm_r <= warm_nxt;
      cold_r <= cold_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign scan_hold = scan_hold_r;
  assign proc_addr = proc_addr_r;
  assign proc_rd = proc_rd_r;
  assign proc_wr = proc_wr_r;
  assign proc_wdata = proc_wdata_r;
  assign backplane_ready = bp_ready_r;
  assign serial_init = ser_init_r;
  assign serial_enable = ser_en_r;
  assign debug_port_enable = dbg_en_r;
  assign warm_restart = warm_r;
  assign cold_restart = cold_r;
endmodule
`default_nettype wire

// ### backplane_cmd_mailbox_properties.sv
`timescale 1ns/1ps
`default_nettype none
module backplane_cmd_mailbox_checker
  import backplane_mailbox_pkg::*;
#(
  parameter int WINDOW_MAX = MAX_WINDOW,
  parameter int TICK_CYCLES = TIME_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic scan_hold,
  input wire logic [15:0] proc_addr,
  input wire logic proc_rd,
  input wire logic proc_wr,
  input wire logic serial_init,
  input wire logic serial_enable,
  input wire logic debug_port_enable
);
  // ----------------------------------------------------------------
  // shadow of configuration and transfer counters
  // ----------------------------------------------------------------
  logic [12:0] up_r, nw_r, nr_r;
  logic [11:0] rcnt_r, wcnt_r;
  logic [15:0] hst_r, ist_r;
  logic cfg_r, hq_r;

  function automatic logic [11:0] clampf(input logic [15:0] v);
    return (int'(v) > WINDOW_MAX) ? 12'(WINDOW_MAX) : v[11:0];
  endfunction

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      up_r <= 13'h0000;
      nw_r <= 13'h0000;
      nr_r <= 13'h0000;
      rcnt_r <= RST_RD_COUNT;
      wcnt_r <= RST_WR_COUNT;
      hst_r <= RST_AREA_START;
      ist_r <= RST_AREA_START;
      cfg_r <= 1'b0;
      hq_r <= 1'b0;
    end else begin
      up_r <= (up_r == 13'h1FFF) ? up_r : up_r + 13'h0001;
      hq_r <= scan_hold;
      nw_r <= (scan_hold && !hq_r) ? 13'h0000 : nw_r + {12'h000, proc_wr};
      nr_r <= (scan_hold && !hq_r) ? 13'h0000 : nr_r + {12'h000, proc_rd};
      if (reg_wr && reg_addr == {1'b0, OFF_RD_COUNT}) rcnt_r <= clampf(reg_wdata);
      if (reg_wr && reg_addr == {1'b0, OFF_WR_COUNT}) wcnt_r <= clampf(reg_wdata);
      if (reg_wr && reg_addr == {1'b0, OFF_HOLD_START}) hst_r <= reg_wdata;
      if (reg_wr && reg_addr == {1'b0, OFF_IN_START}) ist_r <= reg_wdata;
      if (reg_wr && reg_addr == {1'b0, OFF_CTRL} && reg_wdata[CTRL_CFG_DONE]) cfg_r <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_pull_word;
    proc_rd ##1 !proc_rd ##1 !proc_rd;
  endsequence
  sequence s_first_pull;
    ##[0:4] (proc_rd && proc_addr == hst_r - AREA_BASE);
  endsequence

  property p_serial_cfg;
    $rose(serial_enable) |-> cfg_r;
  endproperty
  property p_init_order;
    $rose(serial_init) |-> up_r >= 13'h1000;
  endproperty
  property p_dbg_after_cfg;
    $rose(debug_port_enable) |-> cfg_r;
  endproperty
  property p_hold_move;
    (proc_rd || proc_wr) |-> scan_hold;
  endproperty
  property p_pull_word;
    proc_rd |-> s_pull_word;
  endproperty
  property p_pull_start;
    $rose(scan_hold) |-> s_first_pull;
  endproperty
  property p_pull_step;
    proc_rd && $past(proc_rd, 3) |-> proc_addr == $past(proc_addr, 3) + 16'h0001;
  endproperty
  property p_push_step;
    proc_wr && $past(proc_wr) |-> proc_addr == $past(proc_addr) + 16'h0001;
  endproperty
  property p_push_start;
    proc_wr && !$past(proc_wr) |-> proc_addr == ist_r - AREA_BASE;
  endproperty
  property p_push_count;
    $fell(scan_hold) |-> ##2 (nw_r == 13'(CMD_WORDS) + {1'b0, rcnt_r});
  endproperty
  property p_pull_count;
    $fell(scan_hold) |-> ##2 (nr_r == 13'(CMD_WORDS) + {1'b0, wcnt_r});
  endproperty

  a_serial_cfg: assert property (p_serial_cfg)
    else $error("serial traffic enabled before configuration");
  a_init_order: assert property (p_init_order)
    else $error("serial init before memory clear finished");
  a_dbg_after_cfg: assert property (p_dbg_after_cfg)
    else $error("debug port set up before configuration");
  a_hold_move: assert property (p_hold_move)
    else $error("processor access without scan hold");
  a_pull_word: assert property (p_pull_word)
    else $error("pull word spacing wrong");
  a_pull_start: assert property (p_pull_start)
    else $error("pull did not start at holding area start");
  a_pull_step: assert property (p_pull_step)
    else $error("pull address not consecutive");
  a_push_step: assert property (p_push_step)
    else $error("push address not consecutive");
  a_push_start: assert property (p_push_start)
    else $error("push did not start at input area start");
  a_push_count: assert property (p_push_count)
    else $error("push word count wrong");
  a_pull_count: assert property (p_pull_count)
    else $error("pull word count wrong");
endmodule

bind backplane_cmd_mailbox backplane_cmd_mailbox_checker #(
  .WINDOW_MAX(WINDOW_MAX),
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (.*);
`default_nettype wire

// ### proc_area_model.sv
`timescale 1ns/1ps
`default_nettype none
module proc_area_model (
  input wire logic ref_clk,
  input wire logic [15:0] proc_addr,
  input wire logic proc_rd,
  input wire logic proc_wr,
  input wire logic [15:0] proc_wdata,
  output logic [15:0] proc_rdata
);
  // ----------------------------------------------------------------
  // holding area read by the device, input area written by it
  // ----------------------------------------------------------------
  logic [15:0] hold_mem [0:8191];
  logic [15:0] in_mem [0:8191];
  initial proc_rdata = 16'h5A5A;
  // data valid one cycle after the read pulse, scrambled otherwise
  always @(posedge ref_clk) begin
    if (proc_wr) in_mem[proc_addr[12:0]] <= proc_wdata;
    if (proc_rd) proc_rdata <= hold_mem[proc_addr[12:0]];
    else proc_rdata <= ~proc_rdata;
  end
endmodule
`default_nettype wire

// ### backplane_cmd_mailbox_test.sv
`timescale 1ns/1ps
`default_nettype none
module backplane_cmd_mailbox_test;
  import backplane_mailbox_pkg::*;
  logic ref_clk, rst, reg_wr, reg_rd, scan_end, event_in, scan_hold, proc_rd, proc_wr;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, proc_addr, proc_wdata, proc_rdata;
  logic backplane_ready, serial_init, serial_enable, debug_port_enable;
  logic warm_restart, cold_restart;
  int n_mismatch, n_tests, seed, k;
  logic [15:0] d, seq, hst, ist;
  logic [15:0] cfg [6];
  logic [15:0] exp_db [8];
  logic [15:0] ids [7] = '{BLK_STATUS, BLK_USER_CMD, BLK_CMD_CTRL, BLK_EVENTS,
    BLK_CMD_ERR, BLK_TIME_RD, BLK_TIME_SET};
  logic [15:0] rv [6] = '{16'(RST_RD_START), 16'(RST_RD_COUNT), 16'(RST_WR_START),
    16'(RST_WR_COUNT), RST_AREA_START, RST_AREA_START};

  backplane_cmd_mailbox #(.TICK_CYCLES(10)) u_dut (.*);
  proc_area_model u_proc (.*);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] nseq(input logic [15:0] s);
    return s + SEQ_STEP;
  endfunction
  task automatic wrap_up();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic scan();
    @(posedge ref_clk);
    scan_end <= 1'b1;
    for (k = 0; k < 20 && scan_hold !== 1'b1; k++) @(posedge ref_clk);
    scan_end <= 1'b0;
    if (k == 20) chk(16'h0000, 16'h0001);
    for (k = 0; k < 3000 && scan_hold !== 1'b0; k++) @(posedge ref_clk);
    if (k == 3000) begin
      n_mismatch++;
      wrap_up();
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic cmd(input logic [15:0] id);
    u_proc.hold_mem[hst + 16'h0001] = id;
    seq = seq + 16'h0005;
    u_proc.hold_mem[hst] = seq;
    scan();
    chk(u_proc.in_mem[ist], nseq(seq));
    chk(u_proc.in_mem[ist + 16'h0001], id);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    {rst, reg_wr, reg_rd, scan_end, event_in} = 5'b10000;
    reg_addr = '0;
    reg_wdata = '0;
    {n_mismatch, n_tests, seed, seq} = {32'd0, 32'd0, 32'd9776, 16'h0000};
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(13'(i + 1), d);
      chk(d, rv[i]);
    end
    rd(13'h0FFF, d);
    chk(d, 16'h0000);
    for (int i = 0; i < 3000 && d !== 16'(ST_LOAD_CFG); i++) rd({1'b0, OFF_STATUS}, d);
    chk(d, 16'(ST_LOAD_CFG));
    chk({15'h0000, serial_enable}, 16'h0000);
    wr({1'b0, OFF_CTRL}, 16'h0003);
    for (k = 0; k < 50 && serial_enable !== 1'b1; k++) @(posedge ref_clk);
    chk({15'h0000, serial_enable}, 16'h0001);
    rd({1'b0, OFF_STATUS}, d);
    chk(d, 16'(ST_IDLE));
    chk({15'h0000, backplane_ready}, 16'h0001);
    wr({1'b0, OFF_RD_COUNT}, 16'h0FFF);
    rd({1'b0, OFF_RD_COUNT}, d);
    chk(d, 16'(MAX_WINDOW));
    ist = 16'h0001 + 16'($random(seed) & 255);
    hst = ist + 16'h0400;
    cfg[0] = 16'($random(seed) & 16'h07FF);
    cfg[1] = 16'h0001 + 16'($random(seed) & 7);
    cfg[2] = cfg[0] + 16'h0800;
    cfg[3] = 16'h0001 + 16'($random(seed) & 7);
    cfg[4] = ist + AREA_BASE;
    cfg[5] = hst + AREA_BASE;
    for (int i = 0; i < 6; i++) wr(13'(i + 1), cfg[i]);
    for (int i = 0; i < cfg[1]; i++) begin
      exp_db[i] = 16'($random(seed));
      wr({1'b1, 12'(cfg[0] + i)}, exp_db[i]);
    end
    wr({1'b1, 12'(cfg[2] + cfg[3])}, 16'hA5A5);
    for (int i = 0; i < cfg[3]; i++) u_proc.hold_mem[hst + 64 + i] = 16'($random(seed));
    @(posedge ref_clk);
    event_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    event_in <= 1'b0;
    for (int j = 0; j < 7; j++) begin
      cmd(ids[j]);
      if (ids[j] === BLK_EVENTS) chk(u_proc.in_mem[ist + 16'h0002], 16'h0003);
    end
    for (int i = 0; i < cfg[1]; i++) chk(u_proc.in_mem[ist + 64 + i], exp_db[i]);
    for (int i = 0; i < cfg[3]; i++) begin
      rd({1'b1, 12'(cfg[2] + i)}, d);
      chk(d, u_proc.hold_mem[hst + 64 + i]);
    end
    rd({1'b1, 12'(cfg[2] + cfg[3])}, d);
    chk(d, 16'hA5A5);
    u_proc.hold_mem[hst + 16'h0001] = BLK_TIME_RD;
    scan();
    chk(u_proc.in_mem[ist + 16'h0001], BLK_TIME_SET);
    d = seq;
    u_proc.hold_mem[hst + 16'h0001] = 16'h1234;
    u_proc.hold_mem[hst] = seq + 16'h0005;
    scan();
    chk(u_proc.in_mem[ist], nseq(d));
    chk(u_proc.in_mem[ist + 16'h0001], BLK_TIME_SET);
    wrap_up();
  end
endmodule
`default_nettype wire
